// ===== ldn_pkg.sv
// Shared constants and checksum helper for the direct-level and memory-program link
package ldn_pkg;

  // Frame identifiers, values are arbitrary
  localparam logic [7:0] LDN_ID_DIRECT = 8'h31;
  localparam logic [7:0] LDN_ID_PROGRAM = 8'h32;

  // Frame layout: identifier, four data bytes, checksum
  localparam logic [2:0] LDN_DATA_BYTES = 3'h4;
  localparam logic [7:0] LDN_CSUM_GOOD = 8'hff;
  localparam logic [7:0] LDN_CSUM_SEED = 8'h00;

  // Node locator decoding
  localparam logic [7:0] LDN_BROADCAST = 8'h00;
  localparam logic [7:0] LDN_SUPER_ZONE = 8'h40;
  localparam logic [3:0] LDN_SUPER_FIRST = 4'h5;
  localparam logic [3:0] LDN_SUPER_LAST = 4'h8;
  localparam logic [7:0] LDN_UNCONFIGURED = 8'hff;

  // Memory-program byte 1 layout
  localparam int LDN_ERASE_BIT = 7;
  localparam int LDN_ZERO_BIT = 6;
  localparam logic [5:0] LDN_INDEX_MAX = 6'h10;

  // Transition step timing
  localparam int LDN_CLK_PERIOD_NS = 5;
  localparam int LDN_STEP_TIME_NS = 1000;
  localparam int LDN_STEP_CYCLES = (LDN_STEP_TIME_NS + LDN_CLK_PERIOD_NS - 1) / LDN_CLK_PERIOD_NS;

  // Controller register map
  localparam logic [3:0] LDN_REG_CMD = 4'h0;
  localparam logic [3:0] LDN_REG_DATA = 4'h4;
  localparam logic [3:0] LDN_REG_STATUS = 4'h8;
  localparam int LDN_GO_BIT = 8;
  localparam logic [1:0] LDN_RESP_OKAY = 2'h0;
  localparam logic [1:0] LDN_RESP_SLVERR = 2'h2;
  localparam logic [2:0] LDN_STEP_CSUM = 3'h5;

  // Eight-bit sum with carry wrapped back in
  function automatic logic [7:0] ldn_csum_add(input logic [7:0] s, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction

endpackage

// ===== ldn_link_if.sv
// Byte link between the bus master end and the driver end
`timescale 1ns/10ps
`default_nettype none
interface ldn_link_if;
  logic [7:0] byte_data;
  logic byte_valid;
  logic frame_start;
  logic frame_last;
  modport master (output byte_data, output byte_valid, output frame_start, output frame_last);
  modport device (input byte_data, input byte_valid, input frame_start, input frame_last);
endinterface
`default_nettype wire

// ===== ldn_device.sv
// Driver end: decodes direct-level and memory-program frames
// Summary of operation
// - Byte 1 locator, bytes 2-4 channel levels
// - Accept direct frame only when locator selects this node
// - Enhanced checksum generated and verified
// - Good direct frame drives outputs directly
// - Direct move uses latest transition settings
// - Direct frame replaces selected colour set
// - Direct levels hold until palette applied
// - Master sends colour frame afterwards, palette off
// - Program frame writes addressed memory word
// - Program frame outside programming mode ignored
// - Master avoids program frames in service
// - Byte 1 bits 5:0 index, 0..0x10
// - Master sends byte 1 bit 6 zero
// - Bit 7 set erases before writing
// - Bytes 2,3,4 form word bits 0..23
// - Locator 0xFF flags unconfigured fault
// - Smooth off jumps, on ramps over time
// - Palette flag zero keeps current levels
`timescale 1ns/10ps
`default_nettype none
module ldn_device
  import ldn_pkg::*;
#(
  parameter int STEP_CYCLES = LDN_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Link from the bus master
  ldn_link_if.device link,
  // Node configuration
  input wire logic [7:0] node_locator_in,
  input wire logic prog_mode_in,
  // Colour frame results
  input wire logic colour_apply_in,
  input wire logic [23:0] palette_levels_in,
  input wire logic smooth_enable_in,
  input wire logic [2:0] trans_time_in,
  // Channel outputs
  output logic [7:0] output_channel_one_out,
  output logic [7:0] output_channel_two_out,
  output logic [7:0] output_channel_three_out,
  output logic direct_active_out,
  output logic level_update_out,
  // Memory write port
  output logic nvm_write_out,
  output logic clear_before_write_out,
  output logic [5:0] memory_word_index_out,
  output logic [23:0] nvm_word_out,
  // Diagnostics
  output logic unconfigured_node_fault_out
);

  initial
  begin
    if (STEP_CYCLES < 1 || STEP_CYCLES * 8 > 65536)
      $error("STEP_CYCLES out of range");
  end

  typedef struct packed {
    logic inframe;
    logic [2:0] idx;
    logic [7:0] fid;
    logic [7:0] sum;
    logic [3:0][7:0] data;
    logic [2:0][7:0] target;
    logic [2:0][7:0] level;
    logic direct;
    logic smooth;
    logic [2:0] ttime;
    logic [15:0] tick;
    logic updated;
    logic nvm_wr;
    logic nvm_erase;
    logic [5:0] nvm_idx;
    logic [23:0] nvm_data;
    logic fault;
  } ldn_dev_state_type;

  ldn_dev_state_type s;
  ldn_dev_state_type next_s;

  // Locator selects this node alone, its zone, its super-zone or all
  function automatic logic ldn_selected(input logic [7:0] loc, input logic [7:0] own);
    logic super_member;
    super_member = (own[7:4] >= LDN_SUPER_FIRST) && (own[7:4] <= LDN_SUPER_LAST);
    return (loc == LDN_BROADCAST) || (loc == own) || (loc == {own[7:4], 4'h0})
      || ((loc == LDN_SUPER_ZONE) && super_member);
  endfunction

  // Tick reload for a transition time code, one less than the clock cycles between ramp steps
  function automatic logic [15:0] ldn_step_load(input logic [2:0] tt);
    logic [31:0] cyc;
    cyc = STEP_CYCLES * ({29'h0, tt} + 32'h1) - 32'h1;
    return cyc[15:0];
  endfunction

  always_comb
  begin
    logic [7:0] b;
    logic [7:0] sum_now;
    logic frame_ok;
    b = link.byte_data;
    sum_now = ldn_csum_add(s.sum, b);
    frame_ok = 1'b0;
    next_s = s;
    next_s.updated = 1'b0;
    next_s.nvm_wr = 1'b0;
    next_s.fault = (node_locator_in == LDN_UNCONFIGURED);
    // Palette applied by a colour frame ends direct control
    if (colour_apply_in)
    begin
      next_s.direct = 1'b0;
      next_s.target = palette_levels_in;
      next_s.smooth = smooth_enable_in;
      next_s.ttime = trans_time_in;
      next_s.updated = 1'b1;
    end
    // Byte collection; a new start abandons an unfinished frame
    if (link.byte_valid)
    begin
      if (link.frame_start)
      begin
        next_s.inframe = 1'b1;
        next_s.idx = 3'h0;
        next_s.fid = b;
        next_s.sum = ldn_csum_add(LDN_CSUM_SEED, b);
      end
      else if (s.inframe)
      begin
        next_s.sum = sum_now;
        if (s.idx < LDN_DATA_BYTES)
        begin
          next_s.data[s.idx[1:0]] = b;
          next_s.idx = s.idx + 3'h1;
        end
        if (link.frame_last)
        begin
          next_s.inframe = 1'b0;
          frame_ok = (s.idx == LDN_DATA_BYTES) && (sum_now == LDN_CSUM_GOOD);
        end
        else if (s.idx == LDN_DATA_BYTES)
        begin
          next_s.inframe = 1'b0;
        end
      end
    end
    // Direct-level frame
    if (frame_ok && s.fid == LDN_ID_DIRECT && ldn_selected(s.data[0], node_locator_in))
    begin
      next_s.target[0] = s.data[1];
      next_s.target[1] = s.data[2];
      next_s.target[2] = s.data[3];
      next_s.direct = 1'b1;
      next_s.smooth = smooth_enable_in;
      next_s.ttime = trans_time_in;
      next_s.updated = 1'b1;
    end
    // Memory-program frame, only in programming mode, once per frame
    if (frame_ok && s.fid == LDN_ID_PROGRAM && prog_mode_in && s.data[0][5:0] <= LDN_INDEX_MAX)
    begin
      next_s.nvm_wr = 1'b1;
      next_s.nvm_erase = s.data[0][LDN_ERASE_BIT];
      next_s.nvm_idx = s.data[0][5:0];
      next_s.nvm_data = {s.data[3], s.data[2], s.data[1]};
    end
    // Move levels toward the targets; levels stay put once they match the targets
    if (next_s.updated)
    begin
      next_s.tick = ldn_step_load(next_s.ttime);
      if (!next_s.smooth)
        next_s.level = next_s.target;
    end
    else if (s.level != s.target)
    begin
      if (!s.smooth)
        next_s.level = s.target;
      else if (s.tick == 16'h0)
      begin
        next_s.tick = ldn_step_load(s.ttime);
        for (int ch = 0; ch < 3; ch++)
        begin
          if (s.level[ch] < s.target[ch])
            next_s.level[ch] = s.level[ch] + 8'h01;
          else if (s.level[ch] > s.target[ch])
            next_s.level[ch] = s.level[ch] - 8'h01;
        end
      end
      else
        next_s.tick = s.tick - 16'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign output_channel_one_out = s.level[0];
  assign output_channel_two_out = s.level[1];
  assign output_channel_three_out = s.level[2];
  assign direct_active_out = s.direct;
  assign level_update_out = s.updated;
  assign nvm_write_out = s.nvm_wr;
  assign clear_before_write_out = s.nvm_erase;
  assign memory_word_index_out = s.nvm_idx;
  assign nvm_word_out = s.nvm_data;
  assign unconfigured_node_fault_out = s.fault;

endmodule
`default_nettype wire

// ===== ldn_master.sv
// Bus master end: AXI4-Lite command registers that send frames over the link
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ldn_master
  import ldn_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  // Link to the driver
  ldn_link_if.master link
);

  initial
  begin
    if (ADDR_W < 4)
      $error("ADDR_W must be at least 4");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] fid;
    logic [31:0] data;
    logic busy;
    logic [2:0] step;
    logic [7:0] sum;
    logic [15:0] sent;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_start;
    logic tx_last;
  } ldn_mst_state_type;

  ldn_mst_state_type s;
  ldn_mst_state_type next_s;

  function automatic logic ldn_is_reg(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    return a == {{(ADDR_W-4){1'b0}}, off};
  endfunction

  always_comb
  begin
    logic [7:0] b;
    b = 8'h00;
    next_s = s;
    next_s.tx_valid = 1'b0;
    next_s.tx_start = 1'b0;
    next_s.tx_last = 1'b0;
    // Write address and data, in either order
    if (axi_awvalid_in && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_wdata_in;
      next_s.wstrb = axi_wstrb_in;
    end
    if (s.bvalid && axi_bready_in)
      next_s.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = LDN_RESP_OKAY;
      if (ldn_is_reg(s.awaddr, LDN_REG_DATA))
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (s.wstrb[i])
            next_s.data[i*8 +: 8] = s.wdata[i*8 +: 8];
        end
      end
      else if (ldn_is_reg(s.awaddr, LDN_REG_CMD))
      begin
        if (s.wstrb[1] && s.wdata[LDN_GO_BIT] && !s.busy && s.wstrb[0])
        begin
          next_s.fid = s.wdata[7:0];
          next_s.busy = 1'b1;
          next_s.step = 3'h0;
        end
      end
      else if (!ldn_is_reg(s.awaddr, LDN_REG_STATUS))
        next_s.bresp = LDN_RESP_SLVERR;
    end
    // Read channel
    if (s.rvalid && axi_rready_in)
      next_s.rvalid = 1'b0;
    if (axi_arvalid_in && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = LDN_RESP_OKAY;
      if (ldn_is_reg(axi_araddr_in, LDN_REG_CMD))
        next_s.rdata = {24'h0, s.fid};
      else if (ldn_is_reg(axi_araddr_in, LDN_REG_DATA))
        next_s.rdata = s.data;
      else if (ldn_is_reg(axi_araddr_in, LDN_REG_STATUS))
        next_s.rdata = {s.sent, 15'h0, s.busy};
      else
      begin
        next_s.rdata = 32'h0;
        next_s.rresp = LDN_RESP_SLVERR;
      end
    end
    // Frame transmission, one byte per clock
    b = (s.step == 3'h0) ? s.fid : s.data[(s.step - 3'h1)*8 +: 8];
    if (s.fid == LDN_ID_PROGRAM && s.step == 3'h1)
      b[LDN_ZERO_BIT] = 1'b0;
    if (s.busy)
    begin
      next_s.tx_valid = 1'b1;
      next_s.step = s.step + 3'h1;
      if (s.step == 3'h0)
      begin
        next_s.tx_start = 1'b1;
        next_s.tx_byte = b;
        next_s.sum = ldn_csum_add(LDN_CSUM_SEED, b);
      end
      else if (s.step == LDN_STEP_CSUM)
      begin
        next_s.tx_last = 1'b1;
        next_s.tx_byte = ~s.sum;
        next_s.busy = 1'b0;
        next_s.sent = s.sent + 16'h1;
      end
      else
      begin
        next_s.tx_byte = b;
        next_s.sum = ldn_csum_add(s.sum, b);
      end
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign axi_awready_out = s.awready;
  assign axi_wready_out = s.wready;
  assign axi_bresp_out = s.bresp;
  assign axi_bvalid_out = s.bvalid;
  assign axi_arready_out = s.arready;
  assign axi_rdata_out = s.rdata;
  assign axi_rresp_out = s.rresp;
  assign axi_rvalid_out = s.rvalid;
  assign link.byte_data = s.tx_byte;
  assign link.byte_valid = s.tx_valid;
  assign link.frame_start = s.tx_start;
  assign link.frame_last = s.tx_last;

endmodule
`default_nettype wire

// ===== ldn_link_chk.sv
// Checker on the frame link and the memory write results
`timescale 1ns/10ps
`default_nettype none
module ldn_link_chk
  import ldn_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Link
  input wire logic [7:0] byte_data_in,
  input wire logic byte_valid_in,
  input wire logic frame_start_in,
  input wire logic frame_last_in,
  // Device side
  input wire logic prog_mode_in,
  input wire logic [7:0] node_locator_in,
  input wire logic nvm_write_in,
  input wire logic clear_before_write_in,
  input wire logic [5:0] memory_word_index_in,
  input wire logic [23:0] nvm_word_in,
  input wire logic unconfigured_node_fault_in
);
  logic [4:0][7:0] fb;
  logic [7:0] sum;
  logic [2:0] pos;

  function automatic logic [7:0] wrap(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction

  // Frame bytes and running sum
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      fb <= 40'h0;
      sum <= 8'h00;
      pos <= 3'h0;
    end
    else if (byte_valid_in)
    begin
      sum <= frame_start_in ? byte_data_in : wrap(sum, byte_data_in);
      pos <= frame_start_in ? 3'h1 : pos + 3'h1;
      if (frame_start_in)
        fb[0] <= byte_data_in;
      else if (pos < 3'h5)
        fb[pos] <= byte_data_in;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_start_with_byte: assert property (frame_start_in |-> byte_valid_in)
    else $error("frame start without a byte");
  a_frame_six_bytes: assert property (byte_valid_in && frame_start_in |=>
    (byte_valid_in && !frame_start_in && !frame_last_in) [*4] ##1 (byte_valid_in && frame_last_in))
    else $error("frame is not six consecutive bytes");
  a_checksum_good: assert property (byte_valid_in && frame_last_in |->
    wrap(sum, byte_data_in) == LDN_CSUM_GOOD)
    else $error("checksum byte wrong");
  a_zero_bit_clear: assert property (byte_valid_in && !frame_start_in && pos == 3'h1
    && fb[0] == LDN_ID_PROGRAM |-> !byte_data_in[LDN_ZERO_BIT])
    else $error("program frame reserved bit not zero");
  a_write_after_frame: assert property (nvm_write_in |-> $past(byte_valid_in && frame_last_in)
    && fb[0] == LDN_ID_PROGRAM)
    else $error("memory write not after a program frame");
  a_write_single: assert property (nvm_write_in |=> !nvm_write_in)
    else $error("memory write longer than one cycle");
  a_write_prog_mode: assert property (nvm_write_in |-> $past(prog_mode_in))
    else $error("memory write outside programming mode");
  a_word_layout: assert property (nvm_write_in |-> nvm_word_in == {fb[4], fb[3], fb[2]})
    else $error("stored word bytes misplaced");
  a_index_range: assert property (nvm_write_in |-> memory_word_index_in == fb[1][5:0]
    && memory_word_index_in <= LDN_INDEX_MAX)
    else $error("word index wrong");
  a_erase_flag: assert property (nvm_write_in |-> clear_before_write_in == fb[1][LDN_ERASE_BIT])
    else $error("erase flag wrong");
  a_fault_set: assert property (node_locator_in == LDN_UNCONFIGURED |=> unconfigured_node_fault_in)
    else $error("unconfigured fault missing");
  a_fault_clear: assert property (node_locator_in != LDN_UNCONFIGURED |=> !unconfigured_node_fault_in)
    else $error("unconfigured fault without cause");
endmodule
`default_nettype wire

// ===== test_lin_direct_level_and_nvm_write.sv
// Testbench joining both ends through the link, driven over the register bus
`timescale 1ns/10ps
`default_nettype none
module test_lin_direct_level_and_nvm_write;
  import ldn_pkg::*;
  localparam logic [7:0] LOCS [6] = '{8'h53, 8'h50, 8'h40, 8'h00, 8'h63, 8'hff};
  logic clk, rst_n, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic [3:0] awa, ara, ws;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [7:0] loc, c1, c2, c3;
  logic pm, app, sm, dir, upd, nw, er, flt;
  logic [23:0] pal, word;
  logic [2:0] tt;
  logic [5:0] idx;
  int error_cnt = 0;
  int tests_run = 0;
  int lvl_n = 0;
  int wr_n = 0;
  int sent_n = 0;
  ldn_link_if link_bus();

  ldn_device #(.STEP_CYCLES(1)) ldn_device_inst (.ref_clk_in(clk), .resetn_in(rst_n), .link(link_bus),
    .node_locator_in(loc), .prog_mode_in(pm), .colour_apply_in(app), .palette_levels_in(pal),
    .smooth_enable_in(sm), .trans_time_in(tt), .output_channel_one_out(c1), .output_channel_two_out(c2),
    .output_channel_three_out(c3), .direct_active_out(dir), .level_update_out(upd), .nvm_write_out(nw),
    .clear_before_write_out(er), .memory_word_index_out(idx), .nvm_word_out(word),
    .unconfigured_node_fault_out(flt));
  ldn_master ldn_master_inst (.ref_clk_in(clk), .resetn_in(rst_n), .axi_awaddr_in(awa), .axi_awvalid_in(awv),
    .axi_awready_out(awr), .axi_wdata_in(wd), .axi_wstrb_in(ws), .axi_wvalid_in(wv), .axi_wready_out(wr),
    .axi_bresp_out(br), .axi_bvalid_out(bv), .axi_bready_in(bre), .axi_araddr_in(ara), .axi_arvalid_in(arv),
    .axi_arready_out(arr), .axi_rdata_out(rdat), .axi_rresp_out(rr), .axi_rvalid_out(rv),
    .axi_rready_in(rre), .link(link_bus));
  ldn_link_chk ldn_link_chk_inst (.ref_clk_in(clk), .resetn_in(rst_n), .byte_data_in(link_bus.byte_data),
    .byte_valid_in(link_bus.byte_valid), .frame_start_in(link_bus.frame_start),
    .frame_last_in(link_bus.frame_last), .prog_mode_in(pm), .node_locator_in(loc), .nvm_write_in(nw),
    .clear_before_write_in(er), .memory_word_index_in(idx), .nvm_word_in(word),
    .unconfigured_node_fault_in(flt));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Count result pulses
  always @(posedge clk)
  begin
    if (upd === 1'b1)
      lvl_n++;
    if (nw === 1'b1)
      wr_n++;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    hang("watchdog");
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hang(input string nm);
    error_cnt++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    close_out();
  endtask

  task automatic wait_hi(ref logic s, input string nm);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 500)
        hang(nm);
    end
    while (s !== 1'b1);
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic aw_open;
    logic w_open;
    n = 0;
    aw_open = 1'b1;
    w_open = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (aw_open || w_open)
    begin
      @(posedge clk);
      if (aw_open && awr === 1'b1)
      begin
        aw_open = 1'b0;
        awv <= 1'b0;
      end
      if (w_open && wr === 1'b1)
      begin
        w_open = 1'b0;
        wv <= 1'b0;
      end
      n++;
      if (n > 500)
        hang("write address");
    end
    bre <= 1'b1;
    wait_hi(bv, "write response");
    bre <= 1'b0;
    check("write response", {30'h0, e}, {30'h0, br});
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, input logic [1:0] e);
    ara <= a;
    arv <= 1'b1;
    wait_hi(arr, "read address");
    arv <= 1'b0;
    rre <= 1'b1;
    wait_hi(rv, "read data");
    rre <= 1'b0;
    d = rdat;
    check("read response", {30'h0, e}, {30'h0, rr});
  endtask

  // One frame: data bytes, then the go command; the result lands within the eight-cycle wait
  task automatic send(input logic [7:0] id, input logic [31:0] d);
    logic [31:0] st;
    axi_write(LDN_REG_DATA, d, LDN_RESP_OKAY);
    axi_write(LDN_REG_CMD, {23'h0, 1'b1, id}, LDN_RESP_OKAY);
    repeat (8) @(posedge clk);
    axi_read(LDN_REG_STATUS, st, LDN_RESP_OKAY);
    sent_n++;
    check("busy", 32'h0, {31'h0, st[0]});
    check("frames sent", sent_n, {16'h0, st[31:16]});
    axi_read(LDN_REG_CMD, st, LDN_RESP_OKAY);
    check("identifier readback", {24'h0, id}, st);
    axi_read(LDN_REG_DATA, st, LDN_RESP_OKAY);
    check("data readback", d, st);
  endtask

  function automatic logic sel(input logic [7:0] l);
    return l == loc || l == 8'h00 || l == {loc[7:4], 4'h0} || (l == 8'h40 && loc[7:4] inside {[4'h5:4'h8]});
  endfunction

  initial
  begin
    logic [31:0] d;
    logic [23:0] e;
    logic [7:0] l;
    logic ok;
    int n;
    void'($urandom(32'h001a3b27));
    {rst_n, awv, wv, bre, arv, rre, pm, app, sm} = 9'h000;
    {awa, ara, tt} = 11'h000;
    wd = 32'h0;
    pal = 24'h0;
    ws = 4'hf;
    loc = 8'h53;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_read(4'hc, d, LDN_RESP_SLVERR);
    check("unmapped read data", 32'h0, d);
    axi_write(4'hc, 32'h000001ff, LDN_RESP_SLVERR);
    axi_write(LDN_REG_STATUS, 32'hffffffff, LDN_RESP_OKAY);
    ws <= 4'h1;
    axi_write(LDN_REG_CMD, {23'h0, 1'b1, LDN_ID_DIRECT}, LDN_RESP_OKAY);
    ws <= 4'hf;
    axi_read(LDN_REG_CMD, d, LDN_RESP_OKAY);
    check("partial command", 32'h0, d);
    e = 24'h0;
    for (int i = 0; i < 16; i++)
    begin
      l = i < 6 ? LOCS[i] : 8'($urandom());
      d = $urandom();
      d[7:0] = l;
      n = lvl_n;
      ok = sel(l);
      send(LDN_ID_DIRECT, d);
      if (ok)
        e = d[31:8];
      check("levels", {8'h0, e}, {8'h0, c3, c2, c1});
      check("level pulses", n + ok, lvl_n);
    end
    repeat (4) @(posedge clk);
    check("levels held", {8'h0, e}, {8'h0, c3, c2, c1});
    check("direct active", 32'h1, {31'h0, dir});
    pal <= 24'($urandom());
    app <= 1'b1;
    @(posedge clk);
    app <= 1'b0;
    e = pal;
    repeat (2) @(posedge clk);
    check("palette levels", {8'h0, e}, {8'h0, c3, c2, c1});
    check("direct released", 32'h0, {31'h0, dir});
    n = lvl_n;
    send(8'h33, 32'h00ffff53);
    check("unknown frame", n, lvl_n);
    check("levels kept", {8'h0, e}, {8'h0, c3, c2, c1});
    n = wr_n;
    send(LDN_ID_PROGRAM, 32'h12345601);
    check("writes outside programming", n, wr_n);
    pm <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      d = $urandom();
      d[6:0] = i < 2 ? 7'h10 + i[6:0] : 7'($urandom_range(16));
      d[7] = i[0];
      d[6] = 1'($urandom());
      n = wr_n;
      ok = d[5:0] <= LDN_INDEX_MAX;
      send(LDN_ID_PROGRAM, d);
      check("write count", n + ok, wr_n);
      if (ok)
      begin
        check("index", {26'h0, d[5:0]}, {26'h0, idx});
        check("word", {8'h0, d[31:8]}, {8'h0, word});
        check("erase", {31'h0, d[7]}, {31'h0, er});
      end
    end
    send(LDN_ID_DIRECT, 32'h00000053);
    sm <= 1'b1;
    tt <= 3'h3;
    send(LDN_ID_DIRECT, 32'h10101053);
    check("ramp started", 32'h1, {31'h0, c1 < 8'h10});
    repeat (100) @(posedge clk);
    check("ramp done", 32'h00101010, {8'h0, c3, c2, c1});
    loc <= 8'hff;
    repeat (3) @(posedge clk);
    check("fault", 32'h1, {31'h0, flt});
    loc <= 8'h53;
    sm <= 1'b0;
    rst_n <= 1'b0;
    sent_n = 0;
    repeat (3) @(posedge clk);
    check("levels in reset", 32'h0, {8'h0, c3, c2, c1});
    rst_n <= 1'b1;
    @(posedge clk);
    send(LDN_ID_DIRECT, 32'h01020353);
    check("levels after reset", 32'h00010203, {8'h0, c3, c2, c1});
    close_out();
  end
endmodule
`default_nettype wire
